/* sync_err_map.vh */
// Register map, error codes and field positions for the sync axis error monitor
`ifndef SYNC_ERR_MAP_VH
`define SYNC_ERR_MAP_VH

`define NUM_AXES        4
`define ERR_SYNC_GROUP  16'h3040
`define ERR_SYNC_HOME   16'h3042
`define ERR_SYNC_PEER   16'h3043
`define ERR_SYNC_PULSER 16'h3044
`define ERR_SYNC_MISMAT 16'h3045
`define ERR_TORQUE      16'h3050
`define ERR_SPEED       16'h3051
`define ERR_HOME_AMP    16'h3060
`define ERR_GRP_PULSER  16'h3034

// Word addresses (byte address = 4 * index)
`define A_CTRL          4'h0
`define A_STAT          4'h1
`define A_MASK          4'h2
`define A_CLEAR         4'h3
`define A_THRESH        4'h4
`define A_ERR0          4'h8

// Control register fields
`define C_SYNC_EN       0
`define C_MODE_B        1
`define C_TRQ_EN        2
`define C_TRQ_ERR       3
`define C_SPD_EN        4
`define C_SPD_ERR       5
`define C_AMP_CHK       6
`define C_HOME_OK_LO    8
`define C_HOME_OK_HI    15

`define CTRL_RESET      32'h0000_0000
`define MASK_RESET      4'h0
`define THRESH_RESET    32'h0000_0100

`endif

/* axis_err_check.v */
// Per-axis error detection and code holding
`timescale 1ns/100ps
`default_nettype none
`include "sync_err_map.vh"

module axis_err_check (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Configuration
    input  wire [31:0] ctrl,
    input  wire [31:0] thresh,
    // Axis conditions
    input  wire        grp_chg,
    input  wire        sync_active,
    input  wire        stop_req,
    input  wire        busy,
    input  wire        grp_bad_axis,
    input  wire        sync_home_fail,
    input  wire        home_start,
    input  wire [2:0]  home_method,
    input  wire        peer_fault,
    input  wire        sync_set_chg,
    input  wire        pulser_on,
    input  wire        axgrp_chg,
    input  wire [31:0] move_diff,
    input  wire [15:0] torque,
    input  wire [15:0] trq_hi,
    input  wire [15:0] trq_lo,
    input  wire [15:0] speed,
    input  wire [15:0] spd_hi,
    input  wire [15:0] spd_lo,
    input  wire        amp_home_bad,
    input  wire        clear,
    // Results
    output reg  [15:0] err_code_q,
    output wire        err_evt,
    output wire        stop_axis
);
    reg  [15:0] code_d;
    reg         hit;

    // Signed window test
    function out_of_range;
        input [15:0] v;
        input [15:0] hi;
        input [15:0] lo;
        begin
            out_of_range = ($signed(v) > $signed(hi)) || ($signed(v) < $signed(lo));
        end
    endfunction

    always @* begin
        hit    = 1'b1;
        code_d = 16'h0000;
        if (peer_fault && sync_active) begin
            code_d = `ERR_SYNC_PEER;
        end else if (grp_chg && (sync_active || busy || stop_req)) begin
            code_d = `ERR_SYNC_GROUP;
        end else if (grp_bad_axis) begin
            code_d = `ERR_SYNC_GROUP;
        end else if (sync_home_fail) begin
            code_d = `ERR_SYNC_GROUP;
        end else if (home_start && !ctrl[`C_MODE_B] && ctrl[`C_SYNC_EN]) begin
            code_d = `ERR_SYNC_HOME;
        end else if (home_start && ctrl[`C_MODE_B] && !ctrl[`C_HOME_OK_LO + home_method]) begin
            code_d = `ERR_SYNC_HOME;
        end else if (home_start && ctrl[`C_AMP_CHK] && amp_home_bad) begin
            code_d = `ERR_HOME_AMP;
        end else if (sync_set_chg && pulser_on) begin
            code_d = `ERR_SYNC_PULSER;
        end else if (axgrp_chg && pulser_on) begin
            code_d = `ERR_GRP_PULSER;
        end else if (sync_active && (move_diff > thresh)) begin
            code_d = `ERR_SYNC_MISMAT;
        end else if (ctrl[`C_TRQ_EN] && ctrl[`C_TRQ_ERR] && out_of_range(torque, trq_hi, trq_lo)) begin
            code_d = `ERR_TORQUE;
        end else if (ctrl[`C_SPD_EN] && ctrl[`C_SPD_ERR] && out_of_range(speed, spd_hi, spd_lo)) begin
            code_d = `ERR_SPEED;
        end else begin
            hit = 1'b0;
        end
    end

    assign err_evt   = hit;
    assign stop_axis = hit && (code_d == `ERR_SYNC_PEER);

    // New error wins over a same-cycle clear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_code_q <= 16'h0000;
        end else if (hit) begin
            err_code_q <= code_d;
        end else if (clear) begin
            err_code_q <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

/* sync_axis_error_monitor.v */
// Top: Avalon-MM registers, input synchronisers and four axis checkers
`timescale 1ns/100ps
`default_nettype none
`include "sync_err_map.vh"

module sync_axis_error_monitor (
    // Clock and reset
    input  wire         clk,
    input  wire         rst_n,
    // Avalon-MM slave
    input  wire [3:0]   avs_address,
    input  wire         avs_read,
    input  wire         avs_write,
    input  wire [31:0]  avs_writedata,
    output reg  [31:0]  avs_readdata,
    output wire         avs_waitrequest,
    // Host events, same clock
    input  wire [3:0]   grp_chg,
    input  wire [3:0]   grp_bad_axis,
    input  wire [3:0]   sync_home_fail,
    input  wire [3:0]   home_start,
    input  wire [11:0]  home_method,
    input  wire [3:0]   sync_set_chg,
    input  wire [3:0]   axgrp_chg,
    input  wire [3:0]   sync_member,
    input  wire [3:0]   axis_fault,
    // Pin levels, asynchronous
    input  wire [3:0]   busy_pin,
    input  wire [3:0]   stop_req_pin,
    input  wire [3:0]   pulser_on_pin,
    input  wire [3:0]   amp_home_bad_pin,
    // Servo feedback, same clock
    input  wire [127:0] move_diff,
    input  wire [63:0]  torque,
    input  wire [63:0]  speed,
    input  wire [15:0]  trq_hi,
    input  wire [15:0]  trq_lo,
    input  wire [15:0]  spd_hi,
    input  wire [15:0]  spd_lo,
    // Outputs
    output wire [3:0]   stop_axis,
    output wire         irq
);
    localparam ST_IDLE = 2'b01;
    localparam ST_ACK  = 2'b10;

    reg  [1:0]  state_q;
    reg  [31:0] ctrl_q;
    reg  [31:0] thresh_q;
    reg  [3:0]  stat_q;
    reg  [3:0]  mask_q;
    reg  [3:0]  clr_q;
    reg  [15:0] s1_q;
    reg  [15:0] s2_q;
    reg  [15:0] s3_q;
    reg  [15:0] lvl_q;
    wire [3:0]  evt;
    wire [63:0] codes;
    wire [3:0]  stop_raw;
    wire [3:0]  busy_s;
    wire [3:0]  stop_s;
    wire [3:0]  pulser_s;
    wire [3:0]  ampbad_s;
    wire        wr_acc;
    wire        rd_acc;

    // Three-stage sync, accept when stages two and three agree
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q  <= 16'h0000;
            s2_q  <= 16'h0000;
            s3_q  <= 16'h0000;
            lvl_q <= 16'h0000;
        end else begin
            s1_q  <= {amp_home_bad_pin, pulser_on_pin, stop_req_pin, busy_pin};
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
        end
    end
    assign busy_s   = lvl_q[3:0];
    assign stop_s   = lvl_q[7:4];
    assign pulser_s = lvl_q[11:8];
    assign ampbad_s = lvl_q[15:12];

    // Faulting sync members; each axis looks only at the others
    wire [3:0]  fault_mbr = axis_fault & sync_member;

    genvar g;
    generate
        for (g = 0; g < `NUM_AXES; g = g + 1) begin : gen_axis
            axis_err_check u_chk (
                .clk            (clk),
                .rst_n          (rst_n),
                .ctrl           (ctrl_q),
                .thresh         (thresh_q),
                .grp_chg        (grp_chg[g]),
                .sync_active    (sync_member[g]),
                .stop_req       (stop_s[g]),
                .busy           (busy_s[g]),
                .grp_bad_axis   (grp_bad_axis[g]),
                .sync_home_fail (sync_home_fail[g]),
                .home_start     (home_start[g]),
                .home_method    (home_method[g*3 +: 3]),
                .peer_fault     (|(fault_mbr & ~(4'h1 << g))),
                .sync_set_chg   (sync_set_chg[g]),
                .pulser_on      (pulser_s[g]),
                .axgrp_chg      (axgrp_chg[g]),
                .move_diff      (move_diff[g*32 +: 32]),
                .torque         (torque[g*16 +: 16]),
                .trq_hi         (trq_hi),
                .trq_lo         (trq_lo),
                .speed          (speed[g*16 +: 16]),
                .spd_hi         (spd_hi),
                .spd_lo         (spd_lo),
                .amp_home_bad   (ampbad_s[g]),
                .clear          (clr_q[g]),
                .err_code_q     (codes[g*16 +: 16]),
                .err_evt        (evt[g]),
                .stop_axis      (stop_raw[g])
            );
        end
    endgenerate

    assign stop_axis = stop_raw;

    // One wait state per access
    assign avs_waitrequest = (avs_read || avs_write) && (state_q == ST_IDLE);
    assign wr_acc          = avs_write && (state_q == ST_ACK);
    assign rd_acc          = avs_read && (state_q == ST_IDLE);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (avs_read || avs_write) begin
                        state_q <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Register writes; per-axis clear is a one-cycle pulse
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q   <= `CTRL_RESET;
            thresh_q <= `THRESH_RESET;
            mask_q   <= `MASK_RESET;
            clr_q    <= 4'h0;
            stat_q   <= 4'h0;
        end else begin
            clr_q <= 4'h0;
            if (wr_acc && avs_address == `A_CTRL) begin
                ctrl_q <= avs_writedata;
            end else if (wr_acc && avs_address == `A_THRESH) begin
                thresh_q <= avs_writedata;
            end else if (wr_acc && avs_address == `A_MASK) begin
                mask_q <= avs_writedata[3:0];
            end else if (wr_acc && avs_address == `A_CLEAR) begin
                clr_q <= avs_writedata[3:0];
            end
            // Set wins over write-one-to-clear
            if (wr_acc && avs_address == `A_STAT) begin
                stat_q <= (stat_q & ~avs_writedata[3:0]) | evt;
            end else begin
                stat_q <= stat_q | evt;
            end
        end
    end

    assign irq = |(stat_q & mask_q);

    // Read data loaded in the wait cycle, so it stands when waitrequest drops
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_acc) begin
            if (avs_address == `A_CTRL) begin
                avs_readdata <= ctrl_q;
            end else if (avs_address == `A_STAT) begin
                avs_readdata <= {28'h0000000, stat_q};
            end else if (avs_address == `A_MASK) begin
                avs_readdata <= {28'h0000000, mask_q};
            end else if (avs_address == `A_THRESH) begin
                avs_readdata <= thresh_q;
            end else if (avs_address[3:2] == 2'b10) begin
                avs_readdata <= {16'h0000, codes[avs_address[1:0]*16 +: 16]};
            end else begin
                avs_readdata <= 32'h0000_0000;
            end
        end
    end
endmodule
`default_nettype wire

/* sync_axis_error_monitor_chk.sv */
// Port assertions for the sync axis error monitor
`timescale 1ns/100ps
`default_nettype none
`include "sync_err_map.vh"
module sync_axis_error_monitor_chk (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Register bus
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    // Sync axes and outputs
    input  wire logic [3:0]  sync_member,
    input  wire logic [3:0]  axis_fault,
    input  wire logic [3:0]  stop_axis,
    input  wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic req = avs_read | avs_write;
    wire logic done = req & !avs_waitrequest;
    a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
        else $error("no wait state on new request");
    a_wait_second: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait state longer than one cycle");
    a_wait_again: assert property (done |=> avs_waitrequest || !req)
        else $error("request after completion got no wait");
    a_rdata_only: assert property (!$stable(avs_readdata) |-> $past(avs_read))
        else $error("read data changed outside a read");
    a_irq_fall: assert property ($fell(irq) |-> $past(avs_write && !avs_waitrequest))
        else $error("interrupt dropped without a write");
    a_mask_off: assert property (done && avs_write && avs_address == `A_MASK && avs_writedata[3:0] == 4'h0 |=> !irq)
        else $error("interrupt high with all masked");
    for (genvar g = 0; g < 4; g++) begin : ax
        wire logic [3:0] oth = sync_member & axis_fault & ~(4'h1 << g);
        a_stop_set: assert property (sync_member[g] && |oth |-> stop_axis[g])
            else $error("member not stopped on peer fault");
        a_stop_cause: assert property (stop_axis[g] |-> |oth)
            else $error("stop without a faulting peer");
    end
endmodule
bind sync_axis_error_monitor sync_axis_error_monitor_chk u_chk (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sync_member(sync_member),
    .axis_fault(axis_fault), .stop_axis(stop_axis), .irq(irq));
`default_nettype wire

/* host_servo_model.sv */
// Host controller and servo network model for the monitor's far side
`timescale 1ns/100ps
`default_nettype none
module host_servo_model (
    // Clock
    input  wire logic             clk,
    // Host events: group, bad axis, home fail, home start, sync set, axis group
    output var  logic [5:0][3:0]  ev,
    output var  logic [11:0]      method,
    output var  logic [3:0]       member,
    output var  logic [3:0]       fault,
    // Levels: busy, stop, pulser, amp home bad
    output var  logic [3:0][3:0]  pins,
    // Servo feedback
    output var  logic [127:0]     mdiff,
    output var  logic [63:0]      trq,
    output var  logic [63:0]      spd
);
    initial begin
        ev = '0;
        method = 12'h000;
        member = 4'h0;
        fault = 4'h0;
        pins = '0;
        mdiff = 128'h0;
        trq = 64'h0;
        spd = 64'h0;
    end
    // One-cycle host pulse; quiet levels unless a caller sets them
    task automatic fire(input int k, input int ax);
        @(posedge clk) ev[k][ax] <= 1'b1;
        @(posedge clk) ev[k] <= 4'h0;
    endtask
endmodule
`default_nettype wire

/* sync_axis_error_monitor_bench.sv */
// Self-checking bench for the sync axis error monitor
`timescale 1ns/100ps
`default_nettype none
`include "sync_err_map.vh"
module sync_axis_error_monitor_bench;
    localparam logic signed [15:0] HI = 16'sd1000;
    localparam logic signed [15:0] LO = -16'sd1000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    wire logic [31:0] avs_readdata;
    wire logic avs_waitrequest, irq;
    wire logic [3:0] stop_axis, member, fault;
    wire logic [5:0][3:0] ev;
    wire logic [3:0][3:0] pins;
    wire logic [11:0] method;
    wire logic [127:0] mdiff;
    wire logic [63:0] trq, spd;
    int err_count = 0, checked = 0, seed = 39011;
    logic [31:0] q;
    logic signed [15:0] v;
    always #25 clk = ~clk;
    host_servo_model u_far (.clk(clk), .ev(ev), .method(method), .member(member), .fault(fault),
        .pins(pins), .mdiff(mdiff), .trq(trq), .spd(spd));
    sync_axis_error_monitor u_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .grp_chg(ev[0]), .grp_bad_axis(ev[1]), .sync_home_fail(ev[2]),
        .home_start(ev[3]), .home_method(method), .sync_set_chg(ev[4]), .axgrp_chg(ev[5]),
        .sync_member(member), .axis_fault(fault), .busy_pin(pins[0]), .stop_req_pin(pins[1]),
        .pulser_on_pin(pins[2]), .amp_home_bad_pin(pins[3]), .move_diff(mdiff), .torque(trq), .speed(spd),
        .trq_hi(HI), .trq_lo(LO), .spd_hi(HI), .spd_lo(LO), .stop_axis(stop_axis), .irq(irq));
    task automatic conclude;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        n = 0;
        // Wait state and answer are both judged at the rising edge
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            err_count++;
            conclude();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask
    // Check an axis code, then clear it and all four status bits
    task automatic post(input int ax, input logic [15:0] c);
        rd(4'(`A_ERR0 + ax), {16'h0, c}, "err_code");
        bus(1'b1, `A_CLEAR, 32'h1 << ax);
        bus(1'b1, `A_STAT, 32'hF);
        rd(4'(`A_ERR0 + ax), 32'h0, "err_cleared");
    endtask
    function automatic logic outside(input logic signed [15:0] x);
        return x > HI || x < LO;
    endfunction
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        rd(`A_CTRL, 32'h0, "ctrl");
        rd(`A_THRESH, 32'h100, "thresh");
        rd(`A_MASK, 32'h0, "mask");
        rd(4'hF, 32'h0, "unmapped");
        @(posedge clk) u_far.pins[2] <= 4'h2;
        repeat (6) @(posedge clk);
        u_far.fire(5, 1); post(1, 16'h3034);
        u_far.fire(4, 1); post(1, 16'h3044);
        @(posedge clk) u_far.pins[2] <= 4'h0;
        repeat (6) @(posedge clk);
        u_far.fire(4, 1); post(1, 16'h0000);
        u_far.fire(0, 2); post(2, 16'h0000);
        @(posedge clk) u_far.member <= 4'h4;
        u_far.fire(0, 2); post(2, 16'h3040);
        @(posedge clk) u_far.member <= 4'h0;
        @(posedge clk) u_far.pins[1] <= 4'h4;
        repeat (6) @(posedge clk);
        u_far.fire(0, 2); post(2, 16'h3040);
        @(posedge clk) u_far.pins[1] <= 4'h0;
        u_far.fire(1, 3); post(3, 16'h3040);
        u_far.fire(2, 0); post(0, 16'h3040);
        bus(1'b1, `A_CTRL, 32'h1);
        u_far.fire(3, 0); post(0, 16'h3042);
        bus(1'b1, `A_CTRL, 32'h0402);
        @(posedge clk) u_far.method <= 12'h005;
        u_far.fire(3, 0); post(0, 16'h3042);
        @(posedge clk) u_far.method <= 12'h002;
        u_far.fire(3, 0); post(0, 16'h0000);
        bus(1'b1, `A_CTRL, 32'h40);
        @(posedge clk) u_far.pins[3] <= 4'h8;
        repeat (6) @(posedge clk);
        u_far.fire(3, 3); post(3, 16'h3060);
        @(posedge clk) u_far.member <= 4'h7;
        @(posedge clk) u_far.fault <= 4'h1;
        @(negedge clk) chk("stop_axis", 32'h6, {28'h0, stop_axis});
        @(posedge clk) u_far.fault <= 4'h3;
        @(negedge clk) chk("stop_axis", 32'h7, {28'h0, stop_axis});
        @(posedge clk) u_far.fault <= 4'h0;
        post(1, 16'h3043);
        post(2, 16'h3043);
        post(0, 16'h3043);
        @(posedge clk) u_far.member <= 4'h2;
        @(posedge clk) u_far.mdiff[63:32] <= 32'h100;
        repeat (3) @(posedge clk);
        post(1, 16'h0000);
        @(posedge clk) u_far.mdiff[63:32] <= 32'h101;
        repeat (3) @(posedge clk);
        u_far.mdiff[63:32] <= 32'h0;
        post(1, 16'h3045);
        @(posedge clk) u_far.member <= 4'h0;
        u_far.fire(2, 2);
        repeat (20) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        bus(1'b1, `A_MASK, 32'hF);
        @(negedge clk) chk("irq", 32'h1, {31'h0, irq});
        bus(1'b1, `A_MASK, 32'h0);
        @(negedge clk) chk("irq", 32'h0, {31'h0, irq});
        bus(1'b1, `A_MASK, 32'hF);
        @(negedge clk) chk("irq", 32'h1, {31'h0, irq});
        post(2, 16'h3040);
        @(negedge clk) chk("irq", 32'h0, {31'h0, irq});
        bus(1'b1, `A_CTRL, 32'h3C);
        for (int i = 0; i < 14; i++) begin
            v = (i < 2) ? HI + 16'(i) : 16'($random(seed) % 2200);
            @(posedge clk) if (i[0]) u_far.spd[63:48] <= v; else u_far.trq[63:48] <= v;
            repeat (3) @(posedge clk);
            u_far.spd <= 64'h0;
            u_far.trq <= 64'h0;
            post(3, !outside(v) ? 16'h0000 : i[0] ? 16'h3051 : 16'h3050);
        end
        conclude();
    end
endmodule
`default_nettype wire
